//--- rtl/chs_pkg.sv
// Shared constants and types for the card host strobe port
package chs_pkg;

  // Bus widths
  localparam int CHS_AW = 11;
  localparam int CHS_DW = 16;

  // Clock
  localparam int CLK_PERIOD_NS = 25;

  // Card reset processing time, a least time, so rounded up
  localparam int RESET_PROC_NS  = 1000;
  localparam int RESET_PROC_CYC =
    (RESET_PROC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] RESET_LAST = 8'(RESET_PROC_CYC - 1);

  // Host start-up wait, used where the ready pin cannot be trusted
  localparam int HOST_WAIT_NS  = 2000;
  localparam int HOST_WAIT_CYC =
    (HOST_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] HOST_WAIT_LAST = 8'(HOST_WAIT_CYC - 1);

  // Host strobe cycle phases, least times
  localparam int SETUP_NS  = 50;
  localparam int STROBE_NS = 200;
  localparam int HOLD_NS   = 50;
  localparam int SETUP_CYC  = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC   = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] SETUP_LAST  = 8'(SETUP_CYC - 1);
  localparam logic [7:0] STROBE_LAST = 8'(STROBE_CYC - 1);
  localparam logic [7:0] HOLD_LAST   = 8'(HOLD_CYC - 1);

  // Pin levels and enable encodings
  localparam logic [1:0] CE_NONE      = 2'h3;
  localparam logic [1:0] CE_WORD      = 2'h0;
  localparam logic [1:0] CE_ODD_ONLY  = 2'h1;
  localparam logic [1:0] CE_LOW_BYTE  = 2'h2;
  localparam logic [1:0] CS_TASK      = 2'h2;
  localparam logic [1:0] CS_CTRL      = 2'h1;
  localparam logic [1:0] BE_WORD      = 2'h3;
  localparam logic [1:0] BE_LOW       = 2'h1;
  localparam logic [1:0] BE_HIGH      = 2'h2;
  localparam logic [2:0] IDE_DATA_REG = 3'h0;
  localparam logic [CHS_DW-1:0] BUS_IDLE = 16'hFFFF;
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam logic [7:0] CNT_ONE  = 8'h01;

  // Interface modes
  typedef enum logic [2:0] {
    CHS_MODE_MEM = 3'b001,
    CHS_MODE_IO  = 3'b010,
    CHS_MODE_IDE = 3'b100
  } chs_mode_e;

  // Space an access is routed to
  typedef enum logic [4:0] {
    SP_COMMON = 5'b00001,
    SP_ATTR   = 5'b00010,
    SP_IO     = 5'b00100,
    SP_TASK   = 5'b01000,
    SP_CTRL   = 5'b10000
  } chs_space_e;

  // Host commands
  typedef enum logic [2:0] {
    CMD_MEM_RD  = 3'h0,
    CMD_ATTR_RD = 3'h1,
    CMD_IO_RD   = 3'h2,
    CMD_IO_WR   = 3'h3,
    CMD_IDE_RD  = 3'h4,
    CMD_IDE_WR  = 3'h5
  } chs_cmd_e;

endpackage : chs_pkg

//--- rtl/chs_if.sv
// Pin bundle between the host socket end and the card end
`timescale 1ns/1ps
`default_nettype none
interface chs_if;
  import chs_pkg::*;

  logic [1:0]        card_enable_pair_n;
  logic              io_read_strobe_n;
  logic              io_write_strobe_n;
  logic              output_enable_n;
  logic              space_select_n;
  logic [CHS_AW-1:0] addr;
  logic [CHS_DW-1:0] host_data;
  logic              host_data_oe;
  logic [CHS_DW-1:0] card_data;
  logic              card_data_oe;
  logic              input_ack_n;
  logic              ready_irq;
  wire  [CHS_DW-1:0] data_bus;

  // Shared data wire; an undriven bus reads as pulled high
  assign data_bus = card_data_oe ? card_data :
                    host_data_oe ? host_data : BUS_IDLE;

  modport card (
    input  card_enable_pair_n, io_read_strobe_n, io_write_strobe_n,
    input  output_enable_n, space_select_n, addr, data_bus,
    output card_data, card_data_oe, input_ack_n, ready_irq
  );

  modport host (
    output card_enable_pair_n, io_read_strobe_n, io_write_strobe_n,
    output output_enable_n, space_select_n, addr, host_data, host_data_oe,
    input  data_bus, input_ack_n, ready_irq
  );
endinterface : chs_if
`default_nettype wire

//--- rtl/chs_card_end.sv
// Card end: strobe decode, data drive, acknowledge and ready pin
`timescale 1ns/1ps
`default_nettype none
module chs_card_end
  import chs_pkg::*;
(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  // Host pins
  chs_if.card                    pins,
  // Controller side
  input  wire logic              cfg_io_mode,
  input  wire logic              ctl_busy,
  input  wire logic              ctl_irq,
  input  wire logic [CHS_DW-1:0] ctl_rd_data,
  // Access requests to the controller
  output logic                   acc_valid,
  output logic                   acc_write,
  output chs_space_e             acc_space,
  output logic [CHS_AW-1:0]      acc_addr,
  output logic [CHS_DW-1:0]      acc_wdata,
  output logic [1:0]             acc_byte_en,
  // Status
  output chs_mode_e              card_mode,
  output logic                   card_ready_done
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic              io_read_strobe_n_s1;
    logic              io_read_strobe_n_s2;
    logic              io_write_strobe_n_s1;
    logic              io_write_strobe_n_s2;
    logic              oe_s1;
    logic              oe_s2;
    logic [1:0]        ce_s1;
    logic [1:0]        ce_s2;
    logic              reg_s1;
    logic              reg_s2;
    logic [CHS_AW-1:0] addr_s1;
    logic [CHS_AW-1:0] addr_s2;
    logic [CHS_DW-1:0] data_s1;
    logic [CHS_DW-1:0] data_s2;
    logic [7:0]        rst_cnt;
    logic              done;
    chs_mode_e         mode;
    logic              rd_prev;
    logic              w_pend;
    logic [1:0]        w_ce;
    logic [CHS_AW-1:0] w_addr;
    logic [CHS_DW-1:0] w_data;
    logic              acc_valid;
    logic              acc_write;
    chs_space_e        acc_space;
    logic [CHS_AW-1:0] acc_addr;
    logic [CHS_DW-1:0] acc_wdata;
    logic [1:0]        acc_be;
    logic [CHS_DW-1:0] card_data;
    logic              card_data_oe;
    logic              input_ack_n;
    logic              ready_irq;
  } chs_card_s;

  localparam chs_card_s CARD_RST = '{
    io_read_strobe_n_s1: 1'b1, io_read_strobe_n_s2: 1'b1, io_write_strobe_n_s1: 1'b1, io_write_strobe_n_s2: 1'b1,
    oe_s1: 1'b1, oe_s2: 1'b1, ce_s1: CE_NONE, ce_s2: CE_NONE,
    reg_s1: 1'b1, reg_s2: 1'b1, mode: CHS_MODE_MEM,
    w_ce: CE_NONE, acc_space: SP_COMMON, input_ack_n: 1'b1,
    default: '0
  };

  chs_card_s r;
  chs_card_s n;

  ////////////////////////////////////////////////////////////////////////////
  // Byte lanes from the enable pair or the IDE register choice
  function automatic logic [1:0] lanes(input logic ide,
                                       input logic [1:0] ce,
                                       input logic [CHS_AW-1:0] a);
    logic [1:0] be;
    be = BE_LOW;
    if (ide) begin
      // Only the data register of the task file is a word
      if (ce == CS_TASK && a[2:0] == IDE_DATA_REG) begin
        be = BE_WORD;
      end
    end else begin
      unique case (ce)
        CE_WORD:     be = BE_WORD;
        CE_ODD_ONLY: be = BE_HIGH;
        CE_LOW_BYTE: be = a[0] ? BE_HIGH : BE_LOW;
        default:     be = BE_LOW;
      endcase
    end
    return be;
  endfunction : lanes

  ////////////////////////////////////////////////////////////////////////////
  logic       m_mem;
  logic       m_io;
  logic       m_ide;
  logic       sel;
  logic       rd_io;
  logic       rd_oe;
  logic       rd;
  logic       w_sel;

  always_comb begin
    n = r;
    n.acc_valid = 1'b0;

    n.io_read_strobe_n_s1 = pins.io_read_strobe_n;
    n.io_read_strobe_n_s2 = r.io_read_strobe_n_s1;
    n.io_write_strobe_n_s1 = pins.io_write_strobe_n;
    n.io_write_strobe_n_s2 = r.io_write_strobe_n_s1;
    n.oe_s1   = pins.output_enable_n;
    n.oe_s2   = r.oe_s1;
    n.ce_s1   = pins.card_enable_pair_n;
    n.ce_s2   = r.ce_s1;
    n.reg_s1  = pins.space_select_n;
    n.reg_s2  = r.reg_s1;
    n.addr_s1 = pins.addr;
    n.addr_s2 = r.addr_s1;
    n.data_s1 = pins.data_bus;
    n.data_s2 = r.data_s1;

    if (!r.done) begin
      n.rst_cnt = r.rst_cnt + CNT_ONE;
      if (r.rst_cnt == RESET_LAST) begin
        n.done = 1'b1;
        // Mode strap is the output-enable pin seen at the end of reset
        n.mode = !r.oe_s2 ? CHS_MODE_IDE :
                 cfg_io_mode ? CHS_MODE_IO : CHS_MODE_MEM;
      end
    end else if (r.mode != CHS_MODE_IDE) begin
      // IDE stays latched; memory and I/O follow configuration
      n.mode = cfg_io_mode ? CHS_MODE_IO : CHS_MODE_MEM;
    end

    m_mem = r.done && r.mode == CHS_MODE_MEM;
    m_io  = r.done && r.mode == CHS_MODE_IO;
    m_ide = r.done && r.mode == CHS_MODE_IDE;

    // Either enable low selects the card
    // In IDE the same pair are the two chip selects
    sel = r.ce_s2 != CE_NONE;

    // IDE strobes taken as I/O strobes
    // I/O strobes only outside memory mode
    rd_io = (m_io || m_ide) && sel && !r.io_read_strobe_n_s2 && (m_ide || !r.reg_s2);
    // Output enable reads in memory mode
    // In I/O only attribute reads by enable
    rd_oe = sel && !r.oe_s2 && (m_mem || (m_io && !r.reg_s2));
    rd    = rd_io || rd_oe;
    n.rd_prev = rd;

    // One request per read cycle, at its leading edge
    if (rd && !r.rd_prev) begin
      n.acc_valid = 1'b1;
      n.acc_write = 1'b0;
      n.acc_addr  = r.addr_s2;
      n.acc_be    = lanes(m_ide, r.ce_s2, r.addr_s2);
      if (m_ide) begin
        n.acc_space = r.ce_s2[0] ? SP_CTRL : SP_TASK;
      end else if (rd_io) begin
        n.acc_space = SP_IO;
      end else begin
        n.acc_space = r.reg_s2 ? SP_COMMON : SP_ATTR;
      end
    end

    // Data driven while the synchronised strobe holds, three edges behind the pin
    n.card_data_oe = rd;
    n.card_data    = ctl_rd_data;
    // Acknowledge for I/O mode reads only
    n.input_ack_n  = !(m_io && rd_io);

    // Hold last values seen under the write strobe
    w_sel = r.ce_s2 != CE_NONE && (m_ide || !r.reg_s2);
    if ((m_io || m_ide) && !r.io_write_strobe_n_s2) begin
      n.w_pend = w_sel;
      n.w_ce   = r.ce_s2;
      n.w_addr = r.addr_s2;
      n.w_data = r.data_s2;
    end else if (r.w_pend && r.io_write_strobe_n_s2) begin
      n.w_pend    = 1'b0;
      n.acc_valid = 1'b1;
      n.acc_write = 1'b1;
      n.acc_addr  = r.w_addr;
      n.acc_wdata = r.w_data;
      n.acc_be    = lanes(m_ide, r.w_ce, r.w_addr);
      n.acc_space = m_ide ? (r.w_ce[0] ? SP_CTRL : SP_TASK) : SP_IO;
    end

    // Shared ready pin
    if (!r.done) begin
      n.ready_irq = 1'b0;
    end else if (m_mem) begin
      n.ready_irq = !ctl_busy;
    end else if (m_io) begin
      n.ready_irq = !ctl_irq;
    end else begin
      n.ready_irq = ctl_irq;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      r <= CARD_RST;
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign pins.card_data    = r.card_data;
  assign pins.card_data_oe = r.card_data_oe;
  assign pins.input_ack_n  = r.input_ack_n;
  assign pins.ready_irq    = r.ready_irq;
  assign acc_valid         = r.acc_valid;
  assign acc_write         = r.acc_write;
  assign acc_space         = r.acc_space;
  assign acc_addr          = r.acc_addr;
  assign acc_wdata         = r.acc_wdata;
  assign acc_byte_en       = r.acc_be;
  assign card_mode         = r.mode;
  assign card_ready_done   = r.done;

endmodule : chs_card_end
`default_nettype wire

//--- rtl/chs_host_end.sv
// Host socket end: paced strobe cycles toward the card
`timescale 1ns/1ps
`default_nettype none
module chs_host_end
  import chs_pkg::*;
(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  // Card pins
  chs_if.host                    pins,
  // Mode straps from the system
  input  wire logic              host_ide_mode,
  input  wire logic              host_io_mode,
  // Command port
  input  wire logic              cmd_valid,
  input  wire chs_cmd_e          cmd_kind,
  input  wire logic [CHS_AW-1:0] cmd_addr,
  input  wire logic [CHS_DW-1:0] cmd_wdata,
  input  wire logic [1:0]        cmd_byte_en,
  input  wire logic              cmd_ctrl_sel,
  output logic                   cmd_ready,
  // Answer port
  output logic                   rsp_valid,
  output logic [CHS_DW-1:0]      rsp_rdata,
  output logic                   rsp_ack_seen,
  // Status
  output logic                   card_irq,
  output logic                   card_ready_seen
);

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [4:0] {
    ST_WAIT   = 5'b00001,
    ST_IDLE   = 5'b00010,
    ST_SETUP  = 5'b00100,
    ST_STROBE = 5'b01000,
    ST_HOLD   = 5'b10000
  } chs_hst_e;

  typedef struct packed {
    chs_hst_e          st;
    logic [7:0]        cnt;
    chs_cmd_e          kind;
    logic [1:0]        ce_n;
    logic              io_read_strobe_n_n;
    logic              io_write_strobe_n_n;
    logic              oe_n;
    logic              reg_n;
    logic [CHS_AW-1:0] addr;
    logic [CHS_DW-1:0] data;
    logic              data_oe;
    logic              cmd_ready;
    logic              rsp_valid;
    logic [CHS_DW-1:0] rsp_rdata;
    logic              ack_seen;
    logic              irq;
  } chs_host_s;

  localparam chs_host_s HOST_RST = '{
    st: ST_WAIT, kind: CMD_MEM_RD, ce_n: CE_NONE, io_read_strobe_n_n: 1'b1,
    io_write_strobe_n_n: 1'b1, oe_n: 1'b1, reg_n: 1'b1, default: '0
  };

  chs_host_s r;
  chs_host_s n;
  logic      rd_kind;

  always_comb begin
    n = r;
    n.rsp_valid = 1'b0;
    rd_kind = r.kind != CMD_IO_WR && r.kind != CMD_IDE_WR;
    // Output enable grounded as the IDE strap
    if (host_ide_mode) begin
      n.oe_n = 1'b0;
    end
    // Ready pin read as interrupt in I/O and IDE modes once the card is up; memory mode gives no interrupt
    n.irq = r.st != ST_WAIT &&
            (host_ide_mode ? pins.ready_irq :
             host_io_mode && !pins.ready_irq);
    unique case (r.st)
      ST_WAIT: begin
        // No access until the start-up wait ends and, outside IDE mode, the card reports ready
        if (r.cnt != HOST_WAIT_LAST) begin
          n.cnt = r.cnt + CNT_ONE;
        end else if (host_ide_mode || pins.ready_irq) begin
          n.st        = ST_IDLE;
          n.cmd_ready = 1'b1;
        end
      end
      ST_IDLE: begin
        if (cmd_valid) begin
          n.st        = ST_SETUP;
          n.cnt       = CNT_ZERO;
          n.cmd_ready = 1'b0;
          n.kind      = cmd_kind;
          n.addr      = cmd_addr;
          n.data      = cmd_wdata;
          n.data_oe   = cmd_kind == CMD_IO_WR || cmd_kind == CMD_IDE_WR;
          n.ack_seen  = 1'b0;
          if (cmd_kind == CMD_IDE_RD || cmd_kind == CMD_IDE_WR) begin
            n.ce_n  = cmd_ctrl_sel ? CS_CTRL : CS_TASK;
            n.reg_n = 1'b1;
          end else begin
            // Enables carry byte or word width
            n.ce_n  = ~cmd_byte_en;
            n.reg_n = cmd_kind == CMD_MEM_RD;
          end
        end
      end
      ST_SETUP: begin
        n.cnt = r.cnt + CNT_ONE;
        if (r.cnt == SETUP_LAST) begin
          n.st     = ST_STROBE;
          n.cnt    = CNT_ZERO;
          n.io_read_strobe_n_n = !(r.kind == CMD_IO_RD || r.kind == CMD_IDE_RD);
          n.io_write_strobe_n_n = !(r.kind == CMD_IO_WR || r.kind == CMD_IDE_WR);
          if (!host_ide_mode) begin
            n.oe_n = !(r.kind == CMD_MEM_RD || r.kind == CMD_ATTR_RD);
          end
        end
      end
      ST_STROBE: begin
        n.cnt = r.cnt + CNT_ONE;
        // Acknowledge left unread outside I/O mode
        if (host_io_mode && !pins.input_ack_n) begin
          n.ack_seen = 1'b1;
        end
        if (r.cnt == STROBE_LAST) begin
          n.st        = ST_HOLD;
          n.cnt       = CNT_ZERO;
          n.rsp_rdata = rd_kind ? pins.data_bus : r.rsp_rdata;
          n.io_read_strobe_n_n    = 1'b1;
          n.io_write_strobe_n_n    = 1'b1;
          n.oe_n      = host_ide_mode ? 1'b0 : 1'b1;
        end
      end
      ST_HOLD: begin
        n.cnt = r.cnt + CNT_ONE;
        if (r.cnt == HOLD_LAST) begin
          n.st        = ST_IDLE;
          n.ce_n      = CE_NONE;
          n.reg_n     = 1'b1;
          n.data_oe   = 1'b0;
          n.rsp_valid = 1'b1;
          n.cmd_ready = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      r <= HOST_RST;
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign pins.card_enable_pair_n = r.ce_n;
  assign pins.io_read_strobe_n   = r.io_read_strobe_n_n;
  assign pins.io_write_strobe_n  = r.io_write_strobe_n_n;
  assign pins.output_enable_n    = r.oe_n;
  assign pins.space_select_n     = r.reg_n;
  assign pins.addr               = r.addr;
  assign pins.host_data          = r.data;
  assign pins.host_data_oe       = r.data_oe;
  assign cmd_ready               = r.cmd_ready;
  assign rsp_valid               = r.rsp_valid;
  assign rsp_rdata               = r.rsp_rdata;
  assign rsp_ack_seen            = r.ack_seen;
  assign card_irq                = r.irq;
  assign card_ready_seen         = r.st != ST_WAIT;

endmodule : chs_host_end
`default_nettype wire

//--- tb/chs_chk.sv
// Pin level checker for the card host strobe port
`timescale 1ns/1ps
`default_nettype none
module chs_chk
  import chs_pkg::*;
(
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       rstn,
  // Host driven pins
  input wire logic [1:0] card_enable_pair_n,
  input wire logic       io_read_strobe_n,
  input wire logic       io_write_strobe_n,
  input wire logic       host_data_oe,
  // Card driven pins
  input wire logic       card_data_oe,
  input wire logic       input_ack_n,
  input wire logic       ready_irq
);
  ////////////////////////////////////////////////////////////////////////////
  // Cycles since reset release, saturating so it never wraps
  logic [7:0] since_rst_r;
  logic [7:0] since_rst_nxt;

  always_comb begin
    since_rst_nxt = since_rst_r;
    if (since_rst_r != 8'hFF) begin
      since_rst_nxt = since_rst_r + 8'h01;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      since_rst_r <= 8'h00;
    end else begin
      since_rst_r <= since_rst_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence rd_pulse_s;
    !io_read_strobe_n [*8] ##1 io_read_strobe_n;
  endsequence

  sequence wr_pulse_s;
    (!io_write_strobe_n && host_data_oe) [*8] ##1 io_write_strobe_n;
  endsequence

  a_strobe_excl:
    assert property (io_read_strobe_n || io_write_strobe_n)
    else $error("read and write strobes low together");
  a_rd_width:
    assert property ($fell(io_read_strobe_n) |-> rd_pulse_s)
    else $error("read strobe width wrong");
  a_wr_data_held:
    assert property ($fell(io_write_strobe_n) |-> wr_pulse_s)
    else $error("write strobe or data not held");
  a_no_bus_fight:
    assert property (!(card_data_oe && host_data_oe))
    else $error("both ends drive the data bus");
  a_ack_after_read:
    assert property ($fell(input_ack_n) |-> !$past(io_read_strobe_n, 3))
    else $error("acknowledge without a read strobe");
  a_ack_with_data:
    assert property (!input_ack_n |-> card_data_oe)
    else $error("acknowledge while card not driving");
  a_oe_release:
    assert property ($rose(io_read_strobe_n) && card_data_oe
                     |-> ##[1:4] !card_data_oe)
    else $error("card kept driving after read strobe");
  a_ready_reset_low:
    assert property (since_rst_r <= RESET_LAST |-> !ready_irq)
    else $error("ready high during reset processing");
  a_no_early_access:
    assert property (since_rst_r <= HOST_WAIT_LAST |-> io_read_strobe_n &&
                     io_write_strobe_n && card_enable_pair_n == CE_NONE)
    else $error("host access before start-up wait");
endmodule : chs_chk
`default_nettype wire

//--- tb/chs_tb.sv
// Testbench joining host end and card end through the pin bundle
`timescale 1ns/1ps
`default_nettype none
module chs_tb;
  import chs_pkg::*;
  logic sys_clk, rstn, cfg_io_mode, ctl_busy, ctl_irq;
  logic host_ide_mode, host_io_mode, cmd_valid, cmd_ctrl_sel;
  logic [CHS_DW-1:0] ctl_rd_data, cmd_wdata, acc_wdata, rsp_rdata;
  logic [CHS_AW-1:0] cmd_addr, acc_addr;
  logic [1:0] cmd_byte_en, acc_byte_en;
  chs_cmd_e cmd_kind;
  chs_space_e acc_space;
  chs_mode_e card_mode;
  logic acc_valid, acc_write, card_ready_done, cmd_ready, rsp_valid;
  logic rsp_ack_seen, card_irq, card_ready_seen;
  int n_mismatch = 0;
  int n_compared = 0;
  int acc_cnt = 0;

  chs_if u_if ();
  chs_card_end chs_card_end_i (.sys_clk(sys_clk), .rstn(rstn),
    .pins(u_if.card), .cfg_io_mode(cfg_io_mode), .ctl_busy(ctl_busy),
    .ctl_irq(ctl_irq), .ctl_rd_data(ctl_rd_data), .acc_valid(acc_valid),
    .acc_write(acc_write), .acc_space(acc_space), .acc_addr(acc_addr),
    .acc_wdata(acc_wdata), .acc_byte_en(acc_byte_en),
    .card_mode(card_mode), .card_ready_done(card_ready_done));
  chs_host_end chs_host_end_i (.sys_clk(sys_clk), .rstn(rstn),
    .pins(u_if.host), .host_ide_mode(host_ide_mode),
    .host_io_mode(host_io_mode), .cmd_valid(cmd_valid),
    .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_byte_en(cmd_byte_en), .cmd_ctrl_sel(cmd_ctrl_sel),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .rsp_ack_seen(rsp_ack_seen), .card_irq(card_irq),
    .card_ready_seen(card_ready_seen));
  chs_chk chs_chk_i (.sys_clk(sys_clk), .rstn(rstn),
    .card_enable_pair_n(u_if.card_enable_pair_n),
    .io_read_strobe_n(u_if.io_read_strobe_n),
    .io_write_strobe_n(u_if.io_write_strobe_n),
    .host_data_oe(u_if.host_data_oe), .card_data_oe(u_if.card_data_oe),
    .input_ack_n(u_if.input_ack_n), .ready_irq(u_if.ready_irq));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // Accesses handed to the controller
  always @(posedge sys_clk) begin
    if (acc_valid === 1'b1) acc_cnt++;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                       input string what);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict

  // IDE mode is latched at the end of reset processing; memory and I/O follow cfg_io_mode
  task automatic do_reset(input logic ide, input logic io);
    int n;
    @(posedge sys_clk);
    rstn <= 1'b0;
    host_ide_mode <= ide;
    host_io_mode <= io;
    cfg_io_mode <= io | ide;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (20) @(posedge sys_clk);
    #1;
    check(16'(u_if.ready_irq), 16'h0000, "ready early");
    check(16'(cmd_ready), 16'h0000, "host early");
    n = 0;
    while (cmd_ready !== 1'b1 && n < 400) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check(16'(card_ready_done), 16'h0001, "card not done");
    check(16'(cmd_ready), 16'h0001, "host not ready");
    check(16'(card_ready_seen), 16'h0001, "host not up");
  endtask : do_reset

  task automatic run_cmd(input chs_cmd_e k, input logic [CHS_AW-1:0] a,
    input logic [CHS_DW-1:0] d, input logic [1:0] be, input logic cs1);
    int n;
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_kind <= k;
    cmd_addr <= a;
    cmd_wdata <= d;
    cmd_byte_en <= be;
    cmd_ctrl_sel <= cs1;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (rsp_valid !== 1'b1 && n < 40);
    check(16'(n), 16'(SETUP_CYC + STROBE_CYC + HOLD_CYC), "delay");
    // Card commits a write one edge after the host answers
    @(posedge sys_clk);
    #1;
  endtask : run_cmd

  // Interrupt or busy level shows on the shared ready pin
  task automatic set_level(input logic busy, input logic irq);
    @(posedge sys_clk);
    ctl_busy <= busy;
    ctl_irq <= irq;
    repeat (6) @(posedge sys_clk);
    #1;
  endtask : set_level

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_memory;
    int c;
    do_reset(1'b0, 1'b0);
    check(16'(card_mode), 16'(CHS_MODE_MEM), "mode");
    ctl_rd_data <= 16'h1234;
    run_cmd(CMD_MEM_RD, 11'h010, 16'h0000, BE_WORD, 1'b0);
    check(rsp_rdata, 16'h1234, "common data");
    check(16'(acc_space), 16'(SP_COMMON), "common space");
    run_cmd(CMD_ATTR_RD, 11'h020, 16'h0000, BE_WORD, 1'b0);
    check(16'(acc_space), 16'(SP_ATTR), "attr space");
    c = acc_cnt;
    run_cmd(CMD_IO_RD, 11'h3F0, 16'h0000, BE_WORD, 1'b0);
    check(16'(acc_cnt - c), 16'h0000, "io read taken");
    check(rsp_rdata, BUS_IDLE, "io read drove bus");
    check(16'(rsp_ack_seen), 16'h0000, "ack in memory");
    set_level(1'b1, 1'b0);
    check(16'(u_if.ready_irq), 16'h0000, "busy ready");
    set_level(1'b0, 1'b0);
    check(16'(u_if.ready_irq), 16'h0001, "idle ready");
    $display("test_memory done");
  endtask : test_memory

  task automatic test_io;
    int c;
    do_reset(1'b0, 1'b1);
    check(16'(card_mode), 16'(CHS_MODE_IO), "mode");
    run_cmd(CMD_IO_WR, 11'h3F1, 16'hA55A, BE_WORD, 1'b0);
    check(16'(acc_write), 16'h0001, "write flag");
    check(acc_wdata, 16'hA55A, "write data");
    check(16'(acc_addr), 16'h03F1, "write addr");
    check(16'(acc_space), 16'(SP_IO), "io space");
    run_cmd(CMD_IO_WR, 11'h3F3, 16'h5A00, BE_HIGH, 1'b0);
    check(16'(acc_byte_en), 16'(BE_HIGH), "odd byte");
    ctl_rd_data <= 16'hC3C3;
    run_cmd(CMD_IO_RD, 11'h3F0, 16'h0000, BE_WORD, 1'b0);
    check(rsp_rdata, 16'hC3C3, "io read data");
    check(16'(rsp_ack_seen), 16'h0001, "ack seen");
    run_cmd(CMD_ATTR_RD, 11'h200, 16'h0000, BE_WORD, 1'b0);
    check(16'(acc_space), 16'(SP_ATTR), "attr in io");
    c = acc_cnt;
    run_cmd(CMD_MEM_RD, 11'h010, 16'h0000, BE_WORD, 1'b0);
    check(16'(acc_cnt - c), 16'h0000, "common in io");
    set_level(1'b0, 1'b1);
    check(16'(u_if.ready_irq), 16'h0000, "irq pin");
    check(16'(card_irq), 16'h0001, "irq seen");
    set_level(1'b0, 1'b0);
    $display("test_io done");
  endtask : test_io

  task automatic test_ide;
    do_reset(1'b1, 1'b0);
    check(16'(card_mode), 16'(CHS_MODE_IDE), "mode");
    run_cmd(CMD_IDE_WR, 11'h000, 16'h5AA5, BE_WORD, 1'b0);
    check(16'(acc_space), 16'(SP_TASK), "task space");
    check(acc_wdata, 16'h5AA5, "ide word");
    ctl_rd_data <= 16'h0077;
    run_cmd(CMD_IDE_RD, 11'h006, 16'h0000, BE_LOW, 1'b1);
    check(16'(acc_space), 16'(SP_CTRL), "ctrl space");
    check(16'(rsp_rdata[7:0]), 16'h0077, "ctrl byte");
    set_level(1'b0, 1'b1);
    check(16'(u_if.ready_irq), 16'h0001, "intrq pin");
    check(16'(card_irq), 16'h0001, "intrq seen");
    set_level(1'b0, 1'b0);
    $display("test_ide done");
  endtask : test_ide

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rstn = 1'b0;
    cfg_io_mode = 1'b0;
    ctl_busy = 1'b0;
    ctl_irq = 1'b0;
    ctl_rd_data = 16'h0000;
    host_ide_mode = 1'b0;
    host_io_mode = 1'b0;
    cmd_valid = 1'b0;
    cmd_kind = CMD_MEM_RD;
    cmd_addr = 11'h000;
    cmd_wdata = 16'h0000;
    cmd_byte_en = BE_WORD;
    cmd_ctrl_sel = 1'b0;
    test_memory();
    test_io();
    test_ide();
    print_verdict();
  end

  // Whole run needs well under 2000 cycles
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_mismatch++;
    print_verdict();
  end
endmodule : chs_tb
`default_nettype wire
